// [bopt_pkg.sv]
// Constants and types for the option byte decoder of the storage bridge.
// Assumes the option byte arrives once from the serial EEPROM loader.
package bopt_pkg;
    localparam int unsigned OPT_PAGE8_BIT     = 5;
    localparam int unsigned OPT_POLL_BIT      = 4;
    localparam int unsigned OPT_BUSY_DLY_BIT  = 3;
    localparam int unsigned OPT_SHORT_PKT_BIT = 2;
    localparam logic [7:0]  OPT_BYTE_RESET    = 8'h00;
    localparam logic [5:0]  MODE_PAGE_CACHING = 6'h08;

    localparam int unsigned ADDR_W            = 4;
    localparam logic [3:0]  ADDR_OPTION       = 4'h0;
    localparam logic [3:0]  ADDR_CONTROL      = 4'h4;
    localparam logic [3:0]  ADDR_STATUS       = 4'h8;
    localparam logic        CONTROL_HOLD_RST  = 1'b0;
    localparam int unsigned STAT_LOADED_BIT   = 0;
    localparam int unsigned STAT_DRQ_WAIT_BIT = 1;
    localparam int unsigned STAT_STALL_BIT    = 2;
    localparam int unsigned OPT_LOADED_BIT    = 8;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    localparam int unsigned BUSY_DELAY_MS     = 120;
    localparam int unsigned CLK_FREQ_KHZ      = 125000;
    localparam int unsigned BUSY_DELAY_CYCLES = BUSY_DELAY_MS * CLK_FREQ_KHZ;
    localparam int unsigned DLY_W             = 24;

    typedef enum logic [1:0] {
        REG_OPTION  = 2'h0,
        REG_CONTROL = 2'h1,
        REG_STATUS  = 2'h2,
        REG_NONE    = 2'h3
    } bopt_reg_t;

    typedef enum logic {
        DRQ_IDLE = 1'b0,
        DRQ_WAIT = 1'b1
    } bopt_drq_st_t;

    typedef enum logic {
        STL_IDLE  = 1'b0,
        STL_SHORT = 1'b1
    } bopt_stall_st_t;
endpackage

// [bopt_delay_timer.sv]
// Bounded wait timer used for the DRQ settle delay.
// Assumes start and stop are single-cycle strobes on the same clock.
module bopt_delay_timer #(
    parameter int unsigned LIMIT = bopt_pkg::BUSY_DELAY_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic start,
    input  wire logic stop,
    output logic      expired
);
    import bopt_pkg::*;

    typedef struct packed {
        logic             running;
        logic [DLY_W-1:0] cnt;
        logic             expired;
    } bopt_tmr_state_t;

    localparam logic [DLY_W-1:0] LAST = DLY_W'(LIMIT - 1);

    bopt_tmr_state_t s_r;
    bopt_tmr_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.expired = 1'b0;
        if (start) begin
            s_nxt.running = 1'b1;
            s_nxt.cnt = '0;
        end else if (stop) begin
            s_nxt.running = 1'b0;
        end else if (s_r.running) begin
            if (s_r.cnt == LAST) begin
                s_nxt.running = 1'b0;
                s_nxt.expired = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign expired = s_r.expired;
endmodule

// [bopt_top.sv]
// Option byte decoder: holds the loaded option byte and applies its
// four behaviour bits to page support, completion, DRQ and stall paths.
// Assumes the loader, ATA engine and USB engine share aclk; only the
// drive interrupt pin is asynchronous.
module bopt_top #(
    parameter int unsigned DELAY_CYCLES = bopt_pkg::BUSY_DELAY_CYCLES
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [7:0]                   opt_byte,
    input  wire logic                         opt_valid,
    output logic                              cmd_enable,
    output logic                              mode_page8_enable,
    output logic                              poll_completion_select,
    output logic                              busy_delay_enable,
    output logic                              short_pkt_enable,
    input  wire logic                         page_query,
    input  wire logic [5:0]                   page_code,
    output logic                              page_ack,
    output logic                              page_supported,
    input  wire logic                         drive_intrq,
    input  wire logic                         cmd_active,
    input  wire logic                         status_valid,
    input  wire logic                         status_busy,
    output logic                              status_poll_req,
    output logic                              cmd_complete,
    input  wire logic                         drq_read,
    input  wire logic                         len_mismatch,
    input  wire logic                         drq_bit,
    output logic                              drq_result_valid,
    output logic                              drq_result,
    input  wire logic                         stall_req,
    input  wire logic                         short_pkt_done,
    output logic                              short_pkt_req,
    output logic                              stall_issue,
    input  wire logic [bopt_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [bopt_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import bopt_pkg::*;

    typedef struct packed {
        logic [7:0]     opt;
        logic           loaded;
        logic           hold;
        logic           cmd_en;
        logic           intrq_s1;
        logic           intrq_s2;
        logic           intrq_d;
        logic           poll_req;
        logic           complete;
        logic           page_ack;
        logic           page_sup;
        bopt_drq_st_t   drq_st;
        logic           drq_valid;
        logic           drq_val;
        bopt_stall_st_t stl_st;
        logic           short_req;
        logic           stall;
        logic           awready;
        logic           wready;
        logic           aw_got;
        logic           w_got;
        logic [3:0]     aw_addr;
        logic [31:0]    wdata;
        logic           wstrb0;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           arready;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } bopt_state_t;

    bopt_state_t s_r;
    bopt_state_t s_nxt;
    logic        dly_start;
    logic        dly_stop;
    logic        dly_expired;

    function automatic bopt_reg_t reg_sel(input logic [3:0] addr);
        if (addr == ADDR_OPTION) begin
            return REG_OPTION;
        end else if (addr == ADDR_CONTROL) begin
            return REG_CONTROL;
        end else if (addr == ADDR_STATUS) begin
            return REG_STATUS;
        end else begin
            return REG_NONE;
        end
    endfunction

    bopt_delay_timer #(
        .LIMIT   (DELAY_CYCLES)
    ) u_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (dly_start),
        .stop    (dly_stop),
        .expired (dly_expired)
    );

    always_comb begin
        s_nxt = s_r;
        dly_start = 1'b0;
        dly_stop = 1'b0;
        s_nxt.page_ack = 1'b0;
        s_nxt.complete = 1'b0;
        s_nxt.drq_valid = 1'b0;
        s_nxt.short_req = 1'b0;
        s_nxt.stall = 1'b0;

        // Only the first load after reset counts; later strobes are ignored.
        if (opt_valid && !s_r.loaded) begin
            s_nxt.opt = opt_byte;
            s_nxt.loaded = 1'b1;
        end
        s_nxt.cmd_en = s_r.loaded && !s_r.hold;

        if (page_query) begin
            s_nxt.page_ack = 1'b1;
            s_nxt.page_sup = (page_code != MODE_PAGE_CACHING) ||
                             s_r.opt[OPT_PAGE8_BIT];
        end

        s_nxt.intrq_s1 = drive_intrq;
        s_nxt.intrq_s2 = s_r.intrq_s1;
        s_nxt.intrq_d = s_r.intrq_s2;
        s_nxt.poll_req = s_r.loaded && s_r.opt[OPT_POLL_BIT] &&
                         cmd_active;
        if (s_r.loaded && cmd_active) begin
            if (s_r.opt[OPT_POLL_BIT]) begin
                s_nxt.complete = status_valid && !status_busy;
            end else begin
                s_nxt.complete = s_r.intrq_s2 && !s_r.intrq_d;
            end
        end

        case (s_r.drq_st)
            DRQ_IDLE: begin
                if (drq_read && s_r.loaded) begin
                    if (s_r.opt[OPT_BUSY_DLY_BIT] && len_mismatch &&
                        !drq_bit) begin
                        dly_start = 1'b1;
                        s_nxt.drq_st = DRQ_WAIT;
                    end else begin
                        s_nxt.drq_valid = 1'b1;
                        s_nxt.drq_val = drq_bit;
                    end
                end
            end
            DRQ_WAIT: begin
                if (drq_bit) begin
                    dly_stop = 1'b1;
                    s_nxt.drq_valid = 1'b1;
                    s_nxt.drq_val = 1'b1;
                    s_nxt.drq_st = DRQ_IDLE;
                end else if (dly_expired) begin
                    s_nxt.drq_valid = 1'b1;
                    s_nxt.drq_val = 1'b0;
                    s_nxt.drq_st = DRQ_IDLE;
                end
            end
            default: s_nxt.drq_st = DRQ_IDLE;
        endcase

        case (s_r.stl_st)
            STL_IDLE: begin
                if (stall_req && s_r.opt[OPT_SHORT_PKT_BIT]) begin
                    s_nxt.short_req = 1'b1;
                    s_nxt.stl_st = STL_SHORT;
                end else if (stall_req) begin
                    s_nxt.stall = 1'b1;
                end
            end
            STL_SHORT: begin
                // The stall waits for the short packet to leave first.
                if (short_pkt_done) begin
                    s_nxt.stall = 1'b1;
                    s_nxt.stl_st = STL_IDLE;
                end
            end
            default: s_nxt.stl_st = STL_IDLE;
        endcase

        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.awready = 1'b0;
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.wready = 1'b0;
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (reg_sel(s_r.aw_addr) == REG_CONTROL) begin
                if (s_r.wstrb0) begin
                    s_nxt.hold = s_r.wdata[0];
                end
            end else if (reg_sel(s_r.aw_addr) == REG_NONE) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.awready = 1'b1;
            s_nxt.wready = 1'b1;
        end

        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = 32'h0000_0000;
            s_nxt.rresp = RESP_OKAY;
            if (reg_sel(s_axi_araddr) == REG_OPTION) begin
                s_nxt.rdata[7:0] = s_r.opt;
                s_nxt.rdata[OPT_LOADED_BIT] = s_r.loaded;
            end else if (reg_sel(s_axi_araddr) == REG_CONTROL) begin
                s_nxt.rdata[0] = s_r.hold;
            end else if (reg_sel(s_axi_araddr) == REG_STATUS) begin
                s_nxt.rdata[STAT_LOADED_BIT] = s_r.loaded;
                s_nxt.rdata[STAT_DRQ_WAIT_BIT] = (s_r.drq_st == DRQ_WAIT);
                s_nxt.rdata[STAT_STALL_BIT] = (s_r.stl_st == STL_SHORT);
            end else begin
                s_nxt.rresp = RESP_SLVERR;
            end
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.opt <= OPT_BYTE_RESET;
            s_r.hold <= CONTROL_HOLD_RST;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_enable = s_r.cmd_en;
    assign mode_page8_enable = s_r.opt[OPT_PAGE8_BIT];
    assign poll_completion_select = s_r.opt[OPT_POLL_BIT];
    assign busy_delay_enable = s_r.opt[OPT_BUSY_DLY_BIT];
    assign short_pkt_enable = s_r.opt[OPT_SHORT_PKT_BIT];
    assign page_ack = s_r.page_ack;
    assign page_supported = s_r.page_sup;
    assign status_poll_req = s_r.poll_req;
    assign cmd_complete = s_r.complete;
    assign drq_result_valid = s_r.drq_valid;
    assign drq_result = s_r.drq_val;
    assign short_pkt_req = s_r.short_req;
    assign stall_issue = s_r.stall;
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rvalid = s_r.rvalid;
endmodule

// [bopt_chk.sv]
// Checker for the option byte decoder, bound into bopt_top.
// Assumes DRQ and stall requests arrive only while those paths are idle.
module bopt_chk #(
    parameter int unsigned DELAY_CYCLES = 20
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic [7:0] opt_byte,
    input wire logic       opt_valid,
    input wire logic       mode_page8_enable,
    input wire logic       poll_completion_select,
    input wire logic       busy_delay_enable,
    input wire logic       short_pkt_enable,
    input wire logic       page_query,
    input wire logic [5:0] page_code,
    input wire logic       page_ack,
    input wire logic       page_supported,
    input wire logic       cmd_active,
    input wire logic       status_valid,
    input wire logic       status_busy,
    input wire logic       cmd_complete,
    input wire logic       drq_read,
    input wire logic       len_mismatch,
    input wire logic       drq_bit,
    input wire logic       drq_result_valid,
    input wire logic       drq_result,
    input wire logic       stall_req,
    input wire logic       short_pkt_req,
    input wire logic       stall_issue
);
    timeunit 1ns;
    timeprecision 1ps;
    import bopt_pkg::*;
    localparam int DW = DELAY_CYCLES + 2;
    logic       ld_r;
    logic [3:0] opt_q;
    logic       slow;
    assign opt_q = {mode_page8_enable, poll_completion_select,
                    busy_delay_enable, short_pkt_enable};
    assign slow = busy_delay_enable && len_mismatch && !drq_bit;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_r <= 1'h0;
        end else if (opt_valid) begin
            ld_r <= 1'h1;
        end
    end
    property p_load;
        opt_valid && !ld_r |=> opt_q == $past(opt_byte[5:2]);
    endproperty
    a_load: assert property (p_load)
        else $error("option bits not taken from loaded byte");
    property p_page;
        page_query |=> page_ack && page_supported ==
            ($past(page_code) != MODE_PAGE_CACHING || mode_page8_enable);
    endproperty
    a_page: assert property (p_page)
        else $error("page support answer wrong");
    property p_poll;
        poll_completion_select && cmd_active && status_valid && !status_busy
            |=> cmd_complete;
    endproperty
    a_poll: assert property (p_poll)
        else $error("polled completion missed");
    property p_drq_now;
        ld_r && drq_read && !slow
            |=> drq_result_valid && drq_result == $past(drq_bit);
    endproperty
    a_drq_now: assert property (p_drq_now)
        else $error("undelayed drq answer wrong");
    property p_drq_wait;
        ld_r && drq_read && slow |=> !drq_result_valid ##[1:DW] drq_result_valid;
    endproperty
    a_drq_wait: assert property (p_drq_wait)
        else $error("delayed drq answer out of bounds");
    property p_stall;
        ld_r && stall_req |=> (short_pkt_enable ? short_pkt_req && !stall_issue
                                                : stall_issue && !short_pkt_req);
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall ordering wrong");
    property p_hold;
        ld_r |=> $stable(opt_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("option bits changed after load");
    c_short: cover property (stall_issue && short_pkt_enable);
    c_poll: cover property (cmd_complete && poll_completion_select);
    c_drq: cover property (drq_result_valid && drq_result && busy_delay_enable);
endmodule

bind bopt_top bopt_chk #(.DELAY_CYCLES(DELAY_CYCLES)) i_bopt_chk (.*);

// [bopt_far_side.sv]
// Behavioural drive and USB host facing the option byte decoder.
// Assumes the bench changes lat only between commands.
module bopt_far_side (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       cmd_active,
    input  wire logic       status_poll_req,
    input  wire logic       short_pkt_req,
    input  wire logic [7:0] lat,
    output logic            drive_intrq = 1'h0,
    output logic            status_valid = 1'h0,
    output logic            status_busy = 1'h0,
    output logic            short_pkt_done = 1'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r = 8'h00;
    logic [7:0] pkt_r = 8'h00;
    logic       rd_now;
    assign rd_now = status_poll_req && cnt_r[0];
    // Status clears at twice the interrupt latency, so the two completion
    // modes finish at different times; between reads busy toggles.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 8'h00;
            pkt_r <= 8'h00;
            drive_intrq <= 1'h0;
            status_valid <= 1'h0;
            short_pkt_done <= 1'h0;
        end else begin
            cnt_r <= cmd_active ? cnt_r + 8'h01 : 8'h00;
            drive_intrq <= cmd_active && cnt_r >= lat;
            status_valid <= rd_now;
            status_busy <= rd_now ? cnt_r < {lat[6:0], 1'h0} : !status_busy;
            pkt_r <= short_pkt_req ? lat : pkt_r - {7'h00, pkt_r != 8'h00};
            short_pkt_done <= pkt_r == 8'h01;
        end
    end
endmodule

// [tb_top.sv]
// Self-checking bench for the option byte decoder.
// Assumes bopt_chk is bound in and bopt_far_side plays drive and host.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bopt_pkg::*;
    localparam int DLY = 20;
    logic aclk = 1'h0, aresetn = 1'h0, opt_valid = 1'h0, page_query = 1'h0;
    logic cmd_active = 1'h0, drq_read = 1'h0, len_mismatch = 1'h0;
    logic drq_bit = 1'h0, stall_req = 1'h0, s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic [7:0] opt_byte = 8'h00, lat = 8'h0A;
    logic [5:0] page_code = 6'h00;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic cmd_enable, mode_page8_enable, poll_completion_select, page_ack;
    logic busy_delay_enable, short_pkt_enable, page_supported, cmd_complete;
    logic drive_intrq, status_valid, status_busy, status_poll_req, r;
    logic drq_result_valid, drq_result, short_pkt_done, short_pkt_req;
    logic stall_issue, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [3:0] obits;
    assign obits = {mode_page8_enable, poll_completion_select,
                    busy_delay_enable, short_pkt_enable};
    logic [7:0] row_in[4] = '{8'h00, 8'h3C, 8'h24, 8'hD8};
    logic [3:0] row_out[4] = '{4'h0, 4'hF, 4'h9, 4'h6};
    int n_mismatch = 0, samples_checked = 0, cyc = 0, n;
    bopt_top #(.DELAY_CYCLES(DLY)) i_bopt_top (.*);
    bopt_far_side i_bopt_far_side (.*);
    always #4 aclk = ~aclk;
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task do_reset;
        aresetn <= 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    task load(input logic [7:0] b);
        @(posedge aclk);
        opt_valid <= 1'h1;
        opt_byte <= b;
        @(posedge aclk);
        opt_valid <= 1'h0;
        opt_byte <= ~b;
        repeat (3) @(posedge aclk);
    endtask
    task page(input logic [5:0] c, input logic sup);
        @(posedge aclk);
        page_query <= 1'h1;
        page_code <= c;
        @(posedge aclk);
        page_query <= 1'h0;
        @(posedge aclk);
        chk("page answer", {30'h0, 1'h1, sup}, {30'h0, page_ack, page_supported});
    endtask
    task stall(input logic sp);
        @(posedge aclk);
        stall_req <= 1'h1;
        @(posedge aclk);
        stall_req <= 1'h0;
        @(posedge aclk);
        chk("stall first", {30'h0, sp, !sp}, {30'h0, short_pkt_req, stall_issue});
        while (stall_issue !== 1'h1) @(posedge aclk);
    endtask
    task cmp(input logic poll);
        @(posedge aclk);
        cmd_active <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n == 2) begin
                chk("poll req", {31'h0, poll}, {31'h0, status_poll_req});
            end
        end while (cmd_complete !== 1'h1);
        cmd_active <= 1'h0;
        chk("completion mode", {31'h0, poll}, {31'h0, n > 20});
        repeat (6) @(posedge aclk);
    endtask
    task drq(input logic lm, input int fl);
        @(posedge aclk);
        drq_read <= 1'h1;
        len_mismatch <= lm;
        @(posedge aclk);
        drq_read <= 1'h0;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n == fl) drq_bit <= 1'h1;
        end while (drq_result_valid !== 1'h1);
        r = drq_result;
        drq_bit <= 1'h0;
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task axi_rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    initial begin
        for (int i = 0; i < 4; i++) begin
            do_reset();
            load(row_in[i]);
            chk("option bits", {28'h0, row_out[i]}, {28'h0, obits});
            page(MODE_PAGE_CACHING, row_out[i][3]);
            page(6'h05, 1'h1);
            stall(row_out[i][0]);
            cmp(row_out[i][2]);
            drq(1'h1, 0);
            chk("drq wait", row_out[i][1] ? DLY + 2 : 1, n);
            chk("drq timeout value", 32'h0, {31'h0, r});
            drq(1'h0, 0);
            chk("drq equal length", 32'h1, n);
            if (row_out[i][1]) begin
                drq(1'h1, 5);
                chk("drq early", 32'h3, {r, n < DLY});
            end
        end
        do_reset();
        axi_rd(ADDR_CONTROL);
        chk("control reset", 32'h0, rd);
        axi_wr(ADDR_CONTROL, 32'h1);
        load(8'h24);
        chk("held off", 32'h0, cmd_enable);
        load(8'h18);
        chk("reload ignored", 32'h9, {28'h0, obits});
        axi_wr(ADDR_OPTION, 32'hFF);
        chk("ignored write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        axi_rd(ADDR_OPTION);
        chk("option reg", 32'h124, rd);
        axi_wr(ADDR_CONTROL, 32'h0);
        repeat (3) @(posedge aclk);
        chk("cmd enabled", 32'h1, cmd_enable);
        axi_rd(4'hC);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], rsp});
        axi_wr(4'hC, 32'h0);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
        axi_rd(ADDR_STATUS);
        chk("status reg", 32'h1, rd);
        tally_and_finish();
    end
endmodule
